// *** include/usb_irq_cfg.svh ***
// register offsets, field positions, reset values and timing for the usb global irq block
// assumes inclusion by bare name from the package file only; the design file relies on the package being compiled first
`ifndef USB_IRQ_CFG_SVH
`define USB_IRQ_CFG_SVH
`define OFS_STATUS 12'h004
`define OFS_FLAG_CLEAR 12'h008
`define OFS_FLAG_FORCE 12'h00c
`define OFS_EN_MASK 12'h010
`define OFS_EN_CLEAR 12'h014
`define OFS_EN_SET 12'h018
`define OFS_EP_EN_RST 12'h01c
`define BIT_BUS_IDLE 0
`define BIT_MICROFRAME_START_FLAG 1
`define BIT_SOF 2
`define BIT_RST_END 3
`define BIT_ACTIVITY 4
`define BIT_RSM_END 5
`define BIT_UP_RSM 6
`define CLEARABLE_BITS 32'h0000007f
`define FORCEABLE_BITS 32'hfe00007f
`define MASK_BITS 32'hfe0ff07f
`define EP_IRQ_LSB 12
`define DMA_IRQ_LSB 25
`define EP_EN_LSB 0
`define EP_RST_LSB 16
`define EP_EN_RST_BITS 32'h00ff00ff
`define ZERO_WORD 32'h00000000
`define IDLE_TIME_US 3000
`define CLK_MHZ 100
`define IDLE_CYCLES (`IDLE_TIME_US * `CLK_MHZ)
`endif

// *** include/usb_irq_pkg.sv ***
// types shared by the usb global irq block
// assumes usb_irq_cfg.svh on the include path
`include "usb_irq_cfg.svh"
package usb_irq_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic [7:0] active;
    logic [7:0] in_reset;
  } ep_ctrl_type;
  typedef enum logic [1:0] {
    line_active,
    line_idle_count,
    line_suspended
  } line_state_type;
endpackage

// *** rtl/usb_irq_ctrl.sv ***
// usb device global event status, interrupt enable mask and endpoint enable/reset control
// assumes line events are synchronous pulses from the usb core on core_clk_i, except the
// raw idle-j level, which comes from the transceiver and is synchronised here
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module usb_irq_ctrl (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // apb slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // usb line and core events
  input wire logic line_idle_j_i,
  input wire logic usb_bus_reset_i,
  input wire logic line_bus_activity_flag_i,
  input wire logic self_resume_i,
  input wire logic upstream_resume_i,
  input wire logic host_resume_end_i,
  input wire logic bus_reset_end_i,
  input wire logic frame_start_i,
  input wire logic microframe_start_i,
  input wire logic [7:0] endpoint_irq_i,
  input wire logic [6:0] dma_channel_irq_i,
  // endpoint control
  output usb_irq_pkg::ep_ctrl_type ep_ctrl_o,
  output logic [7:0] ep_logic_reset_o,
  output logic [7:0] ep_toggle_keep_o,
  // interrupt
  output logic usb_irq_o
);
  logic idle_meta;
  logic idle_sync;
  logic [31:0] idle_count;
  usb_irq_pkg::line_state_type line_state;
  usb_irq_pkg::line_state_type next_line_state;
  logic [31:0] event_flags;
  logic [31:0] irq_enable_mask;
  logic [31:0] endpoint_enable_reset;
  usb_irq_pkg::apb_req_type req;

  assign req = '{paddr: paddr_i, psel: psel_i, penable: penable_i,
                 pwrite: pwrite_i, pwdata: pwdata_i};

  // apb decode; every access completes with no wait state
  wire access_phase = req.psel && req.penable;
  wire wr_strobe = access_phase && req.pwrite;
  wire hit_status = req.paddr == `OFS_STATUS;
  wire hit_clear = req.paddr == `OFS_FLAG_CLEAR;
  wire hit_force = req.paddr == `OFS_FLAG_FORCE;
  wire hit_mask = req.paddr == `OFS_EN_MASK;
  wire hit_en_clr = req.paddr == `OFS_EN_CLEAR;
  wire hit_en_set = req.paddr == `OFS_EN_SET;
  wire hit_ep = req.paddr == `OFS_EP_EN_RST;
  wire hit_any = hit_status || hit_clear || hit_force || hit_mask ||
                 hit_en_clr || hit_en_set || hit_ep;
  wire [31:0] clear_bits = (wr_strobe && hit_clear) ? (req.pwdata & `CLEARABLE_BITS)
                                                    : `ZERO_WORD;
  wire [31:0] force_bits = (wr_strobe && hit_force) ? (req.pwdata & `FORCEABLE_BITS)
                                                    : `ZERO_WORD;
  wire [31:0] en_set_bits = (wr_strobe && hit_en_set) ? (req.pwdata & `MASK_BITS)
                                                      : `ZERO_WORD;
  wire [31:0] en_clr_bits = (wr_strobe && hit_en_clr) ? (req.pwdata & `MASK_BITS)
                                                      : `ZERO_WORD;

  // suspend detection: 3 ms of continuous idle j
  wire idle_done = idle_count == (`IDLE_CYCLES - 1);
  always_comb begin
    next_line_state = line_state;
    case (line_state)
      usb_irq_pkg::line_active: begin
        if (idle_sync) begin
          next_line_state = usb_irq_pkg::line_idle_count;
        end
      end
      usb_irq_pkg::line_idle_count: begin
        if (!idle_sync) begin
          next_line_state = usb_irq_pkg::line_active;
        end else if (idle_done) begin
          next_line_state = usb_irq_pkg::line_suspended;
        end
      end
      usb_irq_pkg::line_suspended: begin
        if (!idle_sync) begin
          next_line_state = usb_irq_pkg::line_active;
        end
      end
      default: next_line_state = usb_irq_pkg::line_active;
    endcase
  end
  wire suspend_hit = (line_state == usb_irq_pkg::line_idle_count) && idle_sync &&
                     idle_done;

  // bus_activity_flag only from a filtered line event, never from our own resume
  wire bus_activity_flag_hit = line_bus_activity_flag_i && !self_resume_i;

  // hardware set events; endpoint and dma summaries follow their sources
  logic [31:0] hw_set;
  always_comb begin
    hw_set = `ZERO_WORD;
    hw_set[`BIT_BUS_IDLE] = suspend_hit;
    hw_set[`BIT_MICROFRAME_START_FLAG] = microframe_start_i;
    hw_set[`BIT_SOF] = frame_start_i;
    hw_set[`BIT_RST_END] = bus_reset_end_i;
    hw_set[`BIT_ACTIVITY] = bus_activity_flag_hit;
    hw_set[`BIT_RSM_END] = host_resume_end_i;
    hw_set[`BIT_UP_RSM] = upstream_resume_i;
  end

  // set wins over clear; activity setting knocks out bus idle unless idle is set again
  logic [31:0] next_event_flags;
  always_comb begin
    next_event_flags = (event_flags & ~clear_bits) | hw_set | force_bits;
    if (next_event_flags[`BIT_ACTIVITY] && !event_flags[`BIT_ACTIVITY] &&
        !hw_set[`BIT_BUS_IDLE] && !force_bits[`BIT_BUS_IDLE]) begin
      next_event_flags[`BIT_BUS_IDLE] = 1'b0;
    end
    // endpoint summary mirrors its source, dma summary is its source or a force write; a clear write cannot touch them
    next_event_flags[`EP_IRQ_LSB +: 8] = endpoint_irq_i;
    next_event_flags[`DMA_IRQ_LSB +: 7] = dma_channel_irq_i | force_bits[`DMA_IRQ_LSB +: 7];
  end

  // endpoint enable/reset register; bus reset drops all reset bits
  logic [31:0] next_endpoint_enable_reset;
  always_comb begin
    next_endpoint_enable_reset = endpoint_enable_reset;
    if (wr_strobe && hit_ep) begin
      next_endpoint_enable_reset = req.pwdata & `EP_EN_RST_BITS;
    end
    if (usb_bus_reset_i) begin
      next_endpoint_enable_reset[`EP_RST_LSB +: 8] = 8'h00;
    end
  end

  // read mux; companion registers read zero without side effects
  logic [31:0] read_word;
  always_comb begin
    read_word = `ZERO_WORD;
    if (hit_status) begin
      read_word = event_flags;
    end else if (hit_mask) begin
      read_word = irq_enable_mask;
    end else if (hit_ep) begin
      read_word = endpoint_enable_reset;
    end
  end

  wire irq_next = |(next_event_flags & irq_enable_mask & `MASK_BITS);

  always_ff @(posedge core_clk_i) begin
    idle_meta <= line_idle_j_i;
    idle_sync <= idle_meta;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !idle_sync || line_state != usb_irq_pkg::line_idle_count) begin
      idle_count <= `ZERO_WORD;
    end else begin
      idle_count <= idle_count + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      line_state <= usb_irq_pkg::line_active;
      event_flags <= `ZERO_WORD;
    end else begin
      line_state <= next_line_state;
      event_flags <= next_event_flags;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_enable_mask <= `ZERO_WORD;
    end else begin
      irq_enable_mask <= (irq_enable_mask & ~en_clr_bits) | en_set_bits;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      endpoint_enable_reset <= `ZERO_WORD;
    end else begin
      endpoint_enable_reset <= next_endpoint_enable_reset;
    end
  end

  // endpoint outputs: logic reset while held in reset or disabled, toggle kept while in reset and enabled
  wire [7:0] ep_en = next_endpoint_enable_reset[`EP_EN_LSB +: 8];
  wire [7:0] ep_rst = next_endpoint_enable_reset[`EP_RST_LSB +: 8];
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ep_ctrl_o <= '0;
      ep_logic_reset_o <= 8'hff;
      ep_toggle_keep_o <= 8'h00;
    end else begin
      ep_ctrl_o.active <= ep_en;
      ep_ctrl_o.in_reset <= ep_rst;
      ep_logic_reset_o <= ep_rst | ~ep_en;
      ep_toggle_keep_o <= ep_rst & ep_en;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      usb_irq_o <= 1'b0;
      prdata_o <= `ZERO_WORD;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      usb_irq_o <= irq_next;
      prdata_o <= read_word;
      pready_o <= req.psel && !req.penable;
      pslverr_o <= req.psel && !req.penable && !hit_any;
    end
  end
endmodule

// *** sim/usb_device_irq_and_ep_reset_tb.sv ***
// self-checking bench for usb_irq_ctrl: apb driver, read scoreboard, host model
// assumes zero or more apb wait states and a run far shorter than a 3 ms idle
`timescale 1ns/1ps
module usb_device_irq_and_ep_reset_tb;
  logic core_clk_i = 0, srst_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, irq, idle_j, selfr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, c, exp_q[$];
  logic [7:0] epi = 0, lrst, tkeep;
  logic [6:0] dma = 0, ev;
  usb_irq_pkg::ep_ctrl_type epc;
  int failures = 0, checks_done = 0, cyc = 0;
  usb_irq_ctrl i_usb_irq_ctrl (.core_clk_i(core_clk_i), .srst_i(srst_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .line_idle_j_i(idle_j),
    .usb_bus_reset_i(ev[0]), .line_bus_activity_flag_i(ev[4]), .self_resume_i(selfr),
    .upstream_resume_i(ev[6]), .host_resume_end_i(ev[5]), .bus_reset_end_i(ev[3]),
    .frame_start_i(ev[2]), .microframe_start_i(ev[1]), .endpoint_irq_i(epi),
    .dma_channel_irq_i(dma), .ep_ctrl_o(epc), .ep_logic_reset_o(lrst),
    .ep_toggle_keep_o(tkeep), .usb_irq_o(irq));
  usb_host_model i_usb_host_model (.core_clk_i(core_clk_i), .ev_o(ev), .idle_j_o(idle_j),
    .self_resume_o(selfr));
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp %h got %h", $time, e, g);
    end
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // reads note their expected word; the monitor below compares it at the access edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, e);
    if (!w) exp_q.push_back(e);
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1; penable <= 0;
    @(posedge core_clk_i);
    penable <= 1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge core_clk_i);
  endtask
  always @(posedge core_clk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) check(exp_q.pop_front(), prdata);
    // every mapped word answers without error, anything else must flag one
    if (psel && penable && pready === 1'b1) check(32'(!(paddr inside {12'h004, 12'h008,
      12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c})), 32'(pslverr));
    cyc++;
    if (cyc == 5000) begin
      failures++;
      report_and_stop;
    end
  end
  initial begin
    r = $urandom(45646);
    repeat (10) @(posedge core_clk_i);
    srst_i <= 0;
    @(posedge core_clk_i);
    apb(12'h010, 0, 0, 0);
    apb(12'h01c, 0, 0, 0);
    for (int a = 8; a < 28; a += 4) if (a != 16) apb(a[11:0], 0, 0, 0);
    apb(12'h0fc, 0, 0, 0);
    apb(12'h00c, 1, 32'hffffffff, 0);
    apb(12'h004, 0, 0, 32'h0000007f);
    r = $urandom & 32'h7f;
    apb(12'h008, 1, r, 0);
    apb(12'h004, 0, 0, 32'h7f & ~r);
    r = $urandom;
    apb(12'h018, 1, r, 0);
    apb(12'h010, 0, 0, r & 32'hfe0ff07f);
    c = $urandom;
    apb(12'h014, 1, c, 0);
    apb(12'h010, 1, 32'hffffffff, 0);
    apb(12'h010, 0, 0, r & ~c & 32'hfe0ff07f);
    apb(12'h014, 1, 32'hffffffff, 0);
    apb(12'h018, 1, 32'h1, 0);
    apb(12'h00c, 1, 32'h1, 0);
    @(negedge core_clk_i) check(1, {31'h0, irq});
    @(posedge core_clk_i);
    apb(12'h014, 1, 32'h1, 0);
    @(negedge core_clk_i) check(0, {31'h0, irq});
    @(posedge core_clk_i);
    for (int b = 1; b < 7; b++) begin
      apb(12'h008, 1, 32'hff, 0);
      apb(12'h00c, 1, 32'h1, 0);
      i_usb_host_model.pulse(b, 0);
      apb(12'h004, 0, 0, b == 4 ? 32'h10 : (32'h1 << b) | 32'h1);
    end
    apb(12'h008, 1, 32'hff, 0);
    i_usb_host_model.pulse(4, 1);
    apb(12'h004, 0, 0, 0);
    r = $urandom & 32'h00ff00ff;
    apb(12'h01c, 1, r, 0);
    apb(12'h01c, 0, 0, r);
    check({r[7:0], r[23:16]}, epc);
    check(8'(r[23:16] | ~r[7:0]), lrst);
    check(8'(r[23:16] & r[7:0]), tkeep);
    i_usb_host_model.pulse(0, 0);
    apb(12'h01c, 0, 0, r & 32'hff);
    epi <= 8'($urandom);
    dma <= 7'($urandom);
    @(posedge core_clk_i);
    apb(12'h008, 1, 32'hffffffff, 0);
    apb(12'h004, 0, 0, {dma, 5'h00, epi, 12'h000});
    report_and_stop;
  end
endmodule

// *** sim/usb_host_model.sv ***
// stand-in for the host and line side: one-cycle event pulses
// assumes pulse is entered just after a rising edge of core_clk_i
`timescale 1ns/1ps
module usb_host_model (
  input wire logic core_clk_i,
  output logic [6:0] ev_o,
  output logic idle_j_o,
  output logic self_resume_o
);
  // a 3 ms idle does not fit a short run, so the line stays busy
  initial begin
    ev_o = 7'h00;
    idle_j_o = 1'b0;
    self_resume_o = 1'b0;
  end
  // bit 0 is a bus reset, bits 6..1 sit on their status positions
  task automatic pulse(input int b, input logic s);
    ev_o[b] <= 1'b1;
    self_resume_o <= s;
    @(posedge core_clk_i);
    ev_o <= 7'h00;
    self_resume_o <= 1'b0;
    @(posedge core_clk_i);
  endtask
endmodule

// *** sim/usb_irq_ctrl_asserts.sv ***
// concurrent checks on the usb global irq block, seen from its ports only
// assumes no bus reset arrives on the edge of an endpoint register write
`timescale 1ns/1ps
module usb_irq_ctrl_asserts (
  // clock, reset and apb
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  // usb side
  input wire logic usb_bus_reset_i,
  input wire usb_irq_pkg::ep_ctrl_type ep_ctrl_o,
  input wire logic [7:0] ep_logic_reset_o,
  input wire logic [7:0] ep_toggle_keep_o,
  input wire logic usb_irq_o
);
  wire acc = psel_i & penable_i & pready_o;
  wire ep_wr = acc & pwrite_i & (paddr_i == 12'h01c);
  wire [7:0] wr_en = pwdata_i[7:0];
  wire [7:0] wr_rst = pwdata_i[23:16];
  wire comp_rd = acc & !pwrite_i & (paddr_i == 12'h008 || paddr_i == 12'h00c
    || paddr_i == 12'h014 || paddr_i == 12'h018);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_ep_write;
    ep_wr && !usb_bus_reset_i;
  endsequence
  a_ep_reset_zero:
    assert property ($fell(srst_i) |-> ep_ctrl_o == 16'h0000) else $error("ep reg not zero");
  a_irq_reset_quiet:
    assert property ($fell(srst_i) |-> !usb_irq_o [*2]) else $error("irq with reset mask");
  a_ep_write:
    assert property (s_ep_write ##1 !usb_bus_reset_i |-> ##1
      ep_ctrl_o == {$past(wr_en, 2), $past(wr_rst, 2)}) else $error("ep reg write lost");
  a_bus_reset_clear:
    assert property (usb_bus_reset_i && !ep_wr ##1 !ep_wr |-> ##1 ep_ctrl_o.in_reset == 8'h00)
      else $error("bus reset kept ep reset bits");
  a_logic_reset:
    assert property (ep_logic_reset_o == (ep_ctrl_o.in_reset | ~ep_ctrl_o.active))
      else $error("ep logic reset wrong");
  a_toggle_keep:
    assert property (ep_toggle_keep_o == (ep_ctrl_o.in_reset & ep_ctrl_o.active))
      else $error("toggle keep wrong");
  a_companion_zero:
    assert property (comp_rd |-> prdata_o == 32'h00000000) else $error("companion read nonzero");
  a_mask_clear_irq:
    assert property (acc && pwrite_i && paddr_i == 12'h014 && pwdata_i == 32'hffffffff
      |-> ##2 !usb_irq_o) else $error("irq with mask cleared");
endmodule
bind usb_irq_ctrl usb_irq_ctrl_asserts i_usb_irq_ctrl_asserts (.core_clk_i(core_clk_i),
  .srst_i(srst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .usb_bus_reset_i(usb_bus_reset_i), .ep_ctrl_o(ep_ctrl_o),
  .ep_logic_reset_o(ep_logic_reset_o), .ep_toggle_keep_o(ep_toggle_keep_o),
  .usb_irq_o(usb_irq_o));
